// >>> design/srt_pkg.sv
package srt_pkg;
  // Terminal station addresses (7-bit field)
  localparam logic [6:0] ST_LINE_ACK  = 7'h01;
  localparam logic [6:0] ST_TMR_CTRL  = 7'h02;
  localparam logic [6:0] ST_TMR_COUNT = 7'h03;
  // Command word fields on station 02 writes
  localparam int CMD_MODE_BIT = 0;
  localparam int CMD_RUN_BIT  = 1;
  localparam int CMD_SRC_LSB  = 2;
  localparam int CMD_RATE_LSB = 4;
  // Reset values
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [6:0]  RST_RATE  = 7'h00;
  // Mains and line generator figures
  localparam int MAINS_HZ     = 60;
  localparam int LINE_MAX_HZ  = 7680;
  localparam int MAX_MULT     = LINE_MAX_HZ / MAINS_HZ;
  localparam int OSC_DIV      = 1000;
  // Time base sources
  typedef enum logic [1:0]
  {
    SRC_LINE = 2'h0,
    SRC_OSC  = 2'h1,
    SRC_EXT  = 2'h2
  } srt_src_t;
  // Timer modes
  typedef enum logic
  {
    MODE_ELAPSED  = 1'b0,
    MODE_INTERVAL = 1'b1
  } srt_mode_t;
  // Response codes
  typedef enum logic [2:0]
  {
    RSP_NONE   = 3'b001,
    RSP_REPLY  = 3'b010,
    RSP_REJECT = 3'b100
  } srt_rsp_t;
endpackage : srt_pkg

// >>> design/srt_timer.sv
// How it works
// - Elapsed mode accumulates ticks; count always readable
// - Interval mode counts to limit, then interrupts
// - Timing signal driven onto peripheral bus
// - Time base: line pulse, oscillator or external
// - Line rate is mains multiple, 60-7680 Hz
// - Line pulse feeds timer and other peripherals
// - Station 01 write: none/reply-clear/reject
// - Timer answers on stations 02 and 03, and on station 01 writes only
module srt_timer
  import srt_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire logic              MAINS_IN,
  input  wire logic              EXT_TB_IN,
  input  wire logic              LINE_PRESENT,
  input  wire logic              CMD_VALID,
  input  wire logic              CMD_WRITE,
  input  wire logic [6:0]        CMD_STATION,
  input  wire logic [CNT_W-1:0]  CMD_DATA,
  output logic                   RSP_VALID,
  output srt_pkg::srt_rsp_t      RSP_CODE,
  output logic [CNT_W-1:0]       RSP_DATA,
  output logic                   TMR_IRQ,
  output logic                   LINE_IRQ,
  output logic                   LINE_PULSE,
  output logic                   BUS_TIMING
);
  import srt_pkg::*;

  localparam int PHASE_W = 24;

  // Whole state of the block
  typedef struct packed {
    logic [2:0]       mains_sync;  // Three-stage pin sampler
    logic [2:0]       ext_sync;    // Three-stage pin sampler
    logic             mains_lvl;   // Debounced mains level
    logic             ext_lvl;     // Debounced external level
    logic [PHASE_W-1:0] period;    // Clocks in last mains cycle
    logic [PHASE_W-1:0] phase;     // Clocks since mains edge
    logic [PHASE_W-1:0] acc;       // Rate accumulator
    logic [6:0]       rate;        // Multiplier minus one
    logic [7:0]       sub_cnt;     // Pulses left this mains cycle
    logic             line_flag;   // Line interrupt pending
    logic [9:0]       osc_cnt;     // Free-running oscillator divider
    srt_mode_t        mode;        // Timer mode
    logic             run;         // Timer enabled
    srt_src_t         src;         // Time base select
    logic [CNT_W-1:0] limit;       // Interval target
    logic [CNT_W-1:0] count;       // Accumulated ticks
    logic             tmr_flag;    // Interval interrupt pending
    logic             rsp_valid;   // Answer strobe
    srt_rsp_t         rsp_code;    // Answer kind
    logic [CNT_W-1:0] rsp_data;    // Read data
    logic             line_pulse;  // Registered line pulse
    logic             bus_timing;  // Registered bus timing
  } srt_state_t;

  srt_state_t s_reg;
  srt_state_t s_next;

  // Tick sources derived from current state
  logic mains_edge;
  logic ext_edge;
  logic osc_tick;
  logic line_tick;
  logic tb_tick;
  logic tmr_set;   // Interval target reached this cycle
  logic [PHASE_W-1:0] step;

  // Station decode used in one place
  function automatic logic is_timer_station(input logic [6:0] st);
    is_timer_station = (st == ST_TMR_CTRL) || (st == ST_TMR_COUNT);
  endfunction : is_timer_station

  // Next-state logic
  always_comb
  begin
    s_next = s_reg;
    // Pins pass three flops; a change counts when stages 2 and 3 agree
    s_next.mains_sync = {s_reg.mains_sync[1:0], MAINS_IN};
    s_next.ext_sync   = {s_reg.ext_sync[1:0], EXT_TB_IN};
    if (s_reg.mains_sync[2] == s_reg.mains_sync[1])
    begin
      s_next.mains_lvl = s_reg.mains_sync[2];
    end
    if (s_reg.ext_sync[2] == s_reg.ext_sync[1])
    begin
      s_next.ext_lvl = s_reg.ext_sync[2];
    end
    mains_edge = s_next.mains_lvl & ~s_reg.mains_lvl;
    ext_edge   = s_next.ext_lvl & ~s_reg.ext_lvl;

    // Free-running oscillator as a clock divider
    osc_tick = (s_reg.osc_cnt == 10'(OSC_DIV - 1));
    s_next.osc_cnt = osc_tick ? 10'h000 : s_reg.osc_cnt + 10'h001;

    // Line generator: N pulses per mains cycle, realigned each edge
    // Spacing uses last cycle length, so the first cycle is coarse
    // Too short a measured period would merge pulses, so spacing waits
    step = s_reg.period;
    line_tick = 1'b0;
    s_next.phase = s_reg.phase + 24'h000001;
    s_next.acc   = s_reg.acc + PHASE_W'(s_reg.rate) + 24'h000001;
    if (mains_edge)
    begin
      // Phase lock: every mains edge starts a fresh burst
      s_next.period  = s_reg.phase;
      s_next.phase   = 24'h000000;
      s_next.acc     = 24'h000000;
      s_next.sub_cnt = 8'(s_reg.rate) + 8'h01;
      line_tick      = 1'b1;
    end
    else if ((s_reg.sub_cnt > 8'h01) &&
             (step > PHASE_W'({s_reg.rate, 1'b1})) &&
             (s_reg.acc >= step))
    begin
      s_next.acc     = s_reg.acc - step;
      s_next.sub_cnt = s_reg.sub_cnt - 8'h01;
      line_tick      = 1'b1;
    end
    // Line pulse serves timer and bus alike
    s_next.line_pulse = line_tick & LINE_PRESENT;

    // Time base select
    case (s_reg.src)
      SRC_LINE: tb_tick = s_reg.line_pulse;
      SRC_OSC:  tb_tick = osc_tick;
      SRC_EXT:  tb_tick = ext_edge;
      default:  tb_tick = 1'b0;
    endcase
    // Timing signal onto the bus follows the chosen base
    s_next.bus_timing = tb_tick & s_reg.run;

    // Counter
    tmr_set = 1'b0;
    if (s_reg.run && tb_tick)
    begin
      if (s_reg.mode == MODE_INTERVAL &&
          s_reg.count + 16'h0001 >= s_reg.limit)
      begin
        s_next.count    = RST_COUNT;
        s_next.tmr_flag = 1'b1;
        tmr_set         = 1'b1;
      end
      else
      begin
        s_next.count = s_reg.count + 16'h0001;
      end
    end

    // Line interrupt flag set by every line pulse
    if (s_next.line_pulse)
    begin
      s_next.line_flag = 1'b1;
    end

    // Command handling; answers last one cycle
    s_next.rsp_valid = 1'b0;
    s_next.rsp_code  = RSP_NONE;
    s_next.rsp_data  = '0;
    if (CMD_VALID)
    begin
      if (CMD_WRITE && CMD_STATION == ST_LINE_ACK)
      begin
        // Acknowledge; a new pulse this cycle keeps the flag set
        s_next.rsp_valid = 1'b1;
        if (!LINE_PRESENT)
        begin
          s_next.rsp_code = RSP_NONE;
        end
        else if (s_reg.line_flag)
        begin
          s_next.rsp_code  = RSP_REPLY;
          s_next.line_flag = s_next.line_pulse;
        end
        else
        begin
          s_next.rsp_code = RSP_REJECT;
        end
      end
      else if (is_timer_station(CMD_STATION))
      begin
        s_next.rsp_valid = 1'b1;
        s_next.rsp_code  = RSP_REPLY;
        if (CMD_WRITE && CMD_STATION == ST_TMR_CTRL)
        begin
          // Control word: mode, run, source, line rate
          s_next.mode  = srt_mode_t'(CMD_DATA[CMD_MODE_BIT]);
          s_next.run   = CMD_DATA[CMD_RUN_BIT];
          s_next.src   = srt_src_t'(CMD_DATA[CMD_SRC_LSB +: 2]);
          s_next.rate  = CMD_DATA[CMD_RATE_LSB +: 7];
          s_next.count = RST_COUNT;
          // Clears the pending event; a new one this cycle wins
          s_next.tmr_flag = tmr_set;
        end
        else if (CMD_WRITE)
        begin
          // Interval target; restarts the count
          s_next.limit = CMD_DATA;
          s_next.count = RST_COUNT;
        end
        else if (CMD_STATION == ST_TMR_COUNT)
        begin
          s_next.rsp_data = s_reg.count;
        end
        else
        begin
          // Status: flag, run, mode
          s_next.rsp_data = {13'h0000, s_reg.tmr_flag, s_reg.run,
                             s_reg.mode};
        end
      end
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      s_reg          <= '0;
      s_reg.rate     <= RST_RATE;
      s_reg.count    <= RST_COUNT;
      s_reg.src      <= SRC_LINE;
      s_reg.mode     <= MODE_ELAPSED;
      s_reg.rsp_code <= RSP_NONE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state flops
  assign RSP_VALID  = s_reg.rsp_valid;
  assign RSP_CODE   = s_reg.rsp_code;
  assign RSP_DATA   = s_reg.rsp_data;
  assign TMR_IRQ    = s_reg.tmr_flag;
  assign LINE_IRQ   = s_reg.line_flag;
  assign LINE_PULSE = s_reg.line_pulse;
  assign BUS_TIMING = s_reg.bus_timing;
endmodule : srt_timer

// >>> dv/srt_timer_sva.sv
module srt_timer_sva
  import srt_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RESETN,
  input wire logic              LINE_PRESENT,
  input wire logic              CMD_VALID,
  input wire logic              CMD_WRITE,
  input wire logic [6:0]        CMD_STATION,
  input wire logic              RSP_VALID,
  input wire srt_pkg::srt_rsp_t RSP_CODE,
  input wire logic              TMR_IRQ,
  input wire logic              LINE_IRQ,
  input wire logic              LINE_PULSE,
  input wire logic              BUS_TIMING
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack; // Line acknowledge write
  logic ctl; // Control word write
  logic tmr; // Any timer station command
  // Command decodes
  assign ack = CMD_VALID && CMD_WRITE && CMD_STATION == ST_LINE_ACK;
  assign ctl = CMD_VALID && CMD_WRITE && CMD_STATION == ST_TMR_CTRL;
  assign tmr = CMD_VALID && CMD_STATION inside {ST_TMR_CTRL, ST_TMR_COUNT};
  // One domain only
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_tmr_reply:
    assert property (tmr |=> RSP_VALID && RSP_CODE == RSP_REPLY)
    else $error("timer station not answered");
  a_other_quiet: assert property (!ack && !tmr |=> !RSP_VALID)
    else $error("answer to a foreign station");
  a_ack_absent:
    assert property (ack && !LINE_PRESENT |=> RSP_VALID && RSP_CODE == RSP_NONE)
    else $error("absent generator answered");
  a_ack_reject:
    assert property (ack && LINE_PRESENT && !LINE_IRQ |=> RSP_CODE == RSP_REJECT)
    else $error("acknowledge without interrupt not rejected");
  a_ack_reply:
    assert property (ack && LINE_PRESENT && LINE_IRQ |=> RSP_CODE == RSP_REPLY)
    else $error("acknowledge of interrupt not replied");
  // A tick landing with the write may set the flag again
  a_ctl_clears: assert property (ctl |=> !TMR_IRQ || BUS_TIMING)
    else $error("control write left interval interrupt");
  a_pulse_short: assert property (LINE_PULSE |=> !LINE_PULSE)
    else $error("line pulse longer than one cycle");
  a_timing_short: assert property (BUS_TIMING |=> !BUS_TIMING)
    else $error("timing signal longer than one cycle");
endmodule : srt_timer_sva

// >>> dv/srt_host.sv
module srt_host
  import srt_pkg::*;
(
  input  wire logic              clk,
  output logic                   cmd_valid,
  output logic                   cmd_write,
  output logic [6:0]             cmd_station,
  output logic [15:0]            cmd_data,
  input  wire logic              rsp_valid,
  input  wire srt_pkg::srt_rsp_t rsp_code,
  input  wire logic [15:0]       rsp_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus from time zero
  initial
  begin
    cmd_valid   = 1'b0;
    cmd_write   = 1'b0;
    cmd_station = 7'h00;
    cmd_data    = 16'h0000;
  end
  // One-cycle strobe; answer is read 1 ns after the taking edge
  task automatic send(input logic w, input logic [6:0] st,
    input logic [15:0] d, output logic v, output srt_rsp_t c,
    output logic [15:0] q);
    @(posedge clk);
    #1 cmd_valid = 1'b1;
    cmd_write   = w;
    cmd_station = st;
    cmd_data    = d;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    // Released data inverted so a stale value cannot match
    cmd_data = ~d;
    v = rsp_valid;
    c = rsp_code;
    q = rsp_data;
  endtask : send
endmodule : srt_host

// >>> dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import srt_pkg::*;
  logic        clk, rst_n, mains, ext_tb, line_on, cmd_valid, cmd_write, v;
  logic        rsp_valid, tmr_irq, line_irq, line_pulse, bus_timing;
  logic [6:0]  cmd_station;
  logic [15:0] cmd_data, rsp_data, q;
  srt_rsp_t    rsp_code, c;
  int          bad_count, num_checks, cycles, n_bus, n_line;
  srt_host u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_station(cmd_station), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_code(rsp_code), .rsp_data(rsp_data));
  srt_timer uut (.CLK(clk), .RESETN(rst_n), .MAINS_IN(mains),
    .EXT_TB_IN(ext_tb), .LINE_PRESENT(line_on), .CMD_VALID(cmd_valid),
    .CMD_WRITE(cmd_write), .CMD_STATION(cmd_station), .CMD_DATA(cmd_data),
    .RSP_VALID(rsp_valid), .RSP_CODE(rsp_code), .RSP_DATA(rsp_data),
    .TMR_IRQ(tmr_irq), .LINE_IRQ(line_irq), .LINE_PULSE(line_pulse),
    .BUS_TIMING(bus_timing));
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse counters and hang guard
  always @(posedge clk)
  begin
    cycles++;
    n_bus += (bus_timing === 1'b1);
    n_line += (line_pulse === 1'b1);
    if (cycles == 30000)
    begin
      bad_count++;
      stop_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Slow external ticks so the pin synchroniser sees each edge
  task automatic ext_ticks(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #1 ext_tb = 1'b1;
      repeat (4) @(posedge clk);
      #1 ext_tb = 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (10) @(posedge clk);
  endtask : ext_ticks
  // One shortened mains period of 1000 cycles
  task automatic mains_cycle();
    @(posedge clk);
    #1 mains = 1'b1;
    repeat (500) @(posedge clk);
    #1 mains = 1'b0;
    repeat (499) @(posedge clk);
  endtask : mains_cycle
  task automatic t_timer();
    u_host.send(1'b1, ST_TMR_CTRL, 16'h000a, v, c, q);
    check({13'h0, c}, {13'h0, RSP_REPLY});
    n_bus = 0;
    ext_ticks(5);
    u_host.send(1'b0, ST_TMR_COUNT, 16'h0000, v, c, q);
    check(q, 16'h0005);
    check(n_bus[15:0], 16'h0005);
    u_host.send(1'b1, ST_TMR_COUNT, 16'h0003, v, c, q);
    u_host.send(1'b1, ST_TMR_CTRL, 16'h000b, v, c, q);
    ext_ticks(2);
    check({15'h0, tmr_irq}, 16'h0000);
    ext_ticks(1);
    check({15'h0, tmr_irq}, 16'h0001);
    u_host.send(1'b0, ST_TMR_CTRL, 16'h0000, v, c, q);
    check(q, 16'h0007);
    ext_ticks(2);
    u_host.send(1'b0, ST_TMR_COUNT, 16'h0000, v, c, q);
    check(q, 16'h0002);
    u_host.send(1'b1, ST_TMR_CTRL, 16'h0006, v, c, q);
    check({15'h0, tmr_irq}, 16'h0000);
    repeat (2500) @(posedge clk);
    u_host.send(1'b0, ST_TMR_COUNT, 16'h0000, v, c, q);
    check({15'h0, q inside {16'h0002, 16'h0003}}, 16'h0001);
    $display("timer test done");
  endtask : t_timer
  task automatic t_line();
    u_host.send(1'b1, ST_TMR_CTRL, 16'h0002, v, c, q);
    u_host.send(1'b1, ST_LINE_ACK, 16'h0000, v, c, q);
    check({12'h0, v, c}, {12'h1, RSP_NONE});
    @(posedge clk);
    #1 line_on = 1'b1;
    u_host.send(1'b1, ST_LINE_ACK, 16'h0000, v, c, q);
    check({13'h0, c}, {13'h0, RSP_REJECT});
    n_line = 0;
    mains_cycle();
    check({15'h0, line_irq}, 16'h0001);
    u_host.send(1'b0, ST_TMR_COUNT, 16'h0000, v, c, q);
    check(q, n_line[15:0]);
    u_host.send(1'b1, ST_LINE_ACK, 16'h0000, v, c, q);
    check({12'h0, line_irq, c}, {12'h0, RSP_REPLY});
    u_host.send(1'b1, ST_TMR_CTRL, 16'h0012, v, c, q);
    mains_cycle();
    n_line = 0;
    mains_cycle();
    check(n_line[15:0], 16'h0002);
    u_host.send(1'b0, 7'h05, 16'h0000, v, c, q);
    check({15'h0, v}, 16'h0000);
    $display("line test done");
  endtask : t_line
  // Main sequence
  initial
  begin
    {rst_n, mains, ext_tb, line_on} = 4'h0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    check({tmr_irq, line_irq, bus_timing, rsp_valid, rsp_code},
      {4'h0, RSP_NONE});
    t_timer();
    t_line();
    stop_test();
  end
endmodule : testbench
bind srt_timer srt_timer_sva chk (.CLK(CLK), .RESETN(RESETN),
  .LINE_PRESENT(LINE_PRESENT), .CMD_VALID(CMD_VALID), .CMD_WRITE(CMD_WRITE),
  .CMD_STATION(CMD_STATION), .RSP_VALID(RSP_VALID), .RSP_CODE(RSP_CODE),
  .TMR_IRQ(TMR_IRQ), .LINE_IRQ(LINE_IRQ), .LINE_PULSE(LINE_PULSE),
  .BUS_TIMING(BUS_TIMING));
